// ---- design/cdq_acq_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cdq_cfg.svh"
module cdq_acq_ctrl
  import cdq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [15:0] regWdata,
  input  wire logic        blkStart,
  input  wire logic        gatePin,
  input  wire logic        fastClearPin,
  input  wire logic [11:0] chanValue,
  input  wire logic        chanOverflow,
  output logic      [31:0] regRdata,
  output logic             regAck,
  output logic             regBerr,
  output logic             busy,
  output logic      [4:0]  chanSel,
  output logic             sectionClear
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0] outBuf [2048];   // Multi-event output buffer
  logic [8:0]  thresh [32];     // Kill bit plus threshold per channel
  logic [15:0] simFifo [32];    // Simulated acquisition words

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cdq_state_type state_q, state_d;
  logic [6:0]  cnt_q, cnt_d;               // Conversion timer / sample index
  logic [5:0]  accCnt_q, accCnt_d;         // Accepted words this event
  logic [10:0] wrOff_q, wrOff_d;           // Next data word address
  logic [10:0] commitPtr_q, commitPtr_d;   // End of stored events
  logic [10:0] rdPtr_q, rdPtr_d;           // Readout pointer
  logic [5:0]  storedEv_q, storedEv_d;     // Events waiting in buffer
  logic [23:0] eventCnt_q, eventCnt_d;     // Event counter
  logic        busy_q, busy_d;
  logic [4:0]  chanSel_q, chanSel_d;
  logic        secClr_q, secClr_d;
  logic        gatePrev_q, fcPrev_q;       // Edge detect history
  logic [15:0] bitSet2_q, bitSet2_d;
  logic [15:0] ctrl1_q, ctrl1_d;
  logic [2:0]  irqLevel_q, irqLevel_d;
  logic [7:0]  irqVector_q, irqVector_d;
  logic [7:0]  chainBase_q, chainBase_d;
  logic [10:0] wTestAddr_q, wTestAddr_d;
  logic [10:0] rTestAddr_q, rTestAddr_d;
  logic [15:0] testHi_q, testHi_d;
  logic [4:0]  fifoWp_q, fifoWp_d;
  logic [4:0]  fifoRp_q, fifoRp_d;
  logic        blkDone_q, blkDone_d;       // Event already delivered in block
  logic [31:0] regRdata_q, regRdata_d;
  logic        regAck_q, regAck_d, regBerr_q, regBerr_d;

  // Memory write requests
  logic        bufWe, thrWe, fifoWe;
  logic [10:0] bufWa;
  logic [31:0] bufWd;

  // Helpers
  logic        gateLvl, fcLvl, gateRise, fcRise, trig;
  logic        simAcq, isWr, isRd, accept, smpOv;
  logic [11:0] smpVal;
  logic [31:0] rdWord;
  logic [5:0]  idxNext;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  cdq_sync uGateSync (
    .clk   (clk),
    .reset (reset),
    .pinIn (gatePin),
    .level (gateLvl)
  );
  cdq_sync uFcSync (
    .clk   (clk),
    .reset (reset),
    .pinIn (fastClearPin),
    .level (fcLvl)
  );

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;      cnt_d = cnt_q;          accCnt_d = accCnt_q;
    wrOff_d = wrOff_q;      commitPtr_d = commitPtr_q;
    rdPtr_d = rdPtr_q;      storedEv_d = storedEv_q;
    busy_d = busy_q;        chanSel_d = chanSel_q;  secClr_d = 1'b0;
    bitSet2_d = bitSet2_q;  ctrl1_d = ctrl1_q;      irqLevel_d = irqLevel_q;
    irqVector_d = irqVector_q;  chainBase_d = chainBase_q;
    wTestAddr_d = wTestAddr_q;  rTestAddr_d = rTestAddr_q;  testHi_d = testHi_q;
    fifoWp_d = fifoWp_q;    fifoRp_d = fifoRp_q;    blkDone_d = blkDone_q;
    regRdata_d = 32'h0;     regAck_d = 1'b0;        regBerr_d = 1'b0;
    bufWe = 1'b0;  bufWa = 11'h0;  bufWd = 32'h0;  thrWe = 1'b0;  fifoWe = 1'b0;
    isWr = regWr;
    isRd = regRd;
    simAcq = bitSet2_q[`CDQ_B2_SIM_ACQ];
    gateRise = gateLvl & ~gatePrev_q;
    fcRise = fcLvl & ~fcPrev_q;
    trig = gateRise | (isWr && regAddr == `CDQ_SW_CONVERT);
    // Simulated words replace the analog sections in test mode
    smpVal = simAcq ? simFifo[fifoRp_q][11:0] : chanValue;
    smpOv = simAcq ? simFifo[fifoRp_q][`CDQ_FIFO_OV] : chanOverflow;
    // Kill bit, zero and overflow suppression
    accept = ~thresh[chanSel_q][`CDQ_THR_KILL]
           & (bitSet2_q[`CDQ_B2_ZERO_OFF] | (smpVal > {thresh[chanSel_q][7:0], 4'h0}))
           & (bitSet2_q[`CDQ_B2_OVR_OFF] | ~smpOv);
    idxNext = {1'b0, cnt_q[4:0]} + 6'h01;
    rdWord = outBuf[rdPtr_q];
    // Event counter: clear write first, a new event still counts
    eventCnt_d = ((isWr && regAddr == `CDQ_EVCNT_RESET) ? 24'h0 : eventCnt_q)
               + {23'h0, (state_q == ST_IDLE) & trig};

    // Acquisition sequencer
    case (state_q)
      ST_IDLE: begin
        if (trig) begin
          state_d = ST_CONV;
          busy_d = 1'b1;
          cnt_d = 7'h0;
          accCnt_d = 6'h0;
          wrOff_d = commitPtr_q + 11'h001;
        end
      end
      ST_CONV: begin
        if (fcRise) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          secClr_d = 1'b1;
        end else if (cnt_q == 7'(`CDQ_CONV_CYCLES - 1)) begin
          state_d = ST_SAMPLE;
          cnt_d = 7'h0;
          chanSel_d = 5'h0;
        end else begin
          cnt_d = cnt_q + 7'h01;
        end
      end
      ST_SAMPLE: begin
        // Output order: 0, 16, 1, 17 ... 15, 31
        if (accept) begin
          bufWe = 1'b1;
          bufWa = wrOff_q;
          bufWd = {5'h0, `CDQ_TYPE_DATA, 3'h0, chanSel_q, 3'h0, smpOv, smpVal};
          wrOff_d = wrOff_q + 11'h001;
          accCnt_d = accCnt_q + 6'h01;
        end
        if (simAcq) begin
          fifoRp_d = fifoRp_q + 5'h01;
        end
        cnt_d = {1'b0, idxNext};
        chanSel_d = {idxNext[0], idxNext[4:1]};
        if (cnt_q[4:0] == `CDQ_LAST_CHAN) begin
          state_d = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (accCnt_q == 6'h0 && !bitSet2_q[`CDQ_B2_EMPTY_EN]) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          secClr_d = 1'b1;
        end else begin
          bufWe = 1'b1;
          bufWa = commitPtr_q;
          bufWd = {5'h0, `CDQ_TYPE_HEAD, 10'h0, accCnt_q, 8'h0};
          state_d = ST_EOB;
        end
      end
      ST_EOB: begin
        bufWe = 1'b1;
        bufWa = wrOff_q;
        bufWd = {5'h0, `CDQ_TYPE_EOB, eventCnt_q};
        commitPtr_d = wrOff_q + 11'h001;
        state_d = ST_FULL;
      end
      ST_FULL: begin
        if (storedEv_q != `CDQ_MEB_EVENTS) begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
          secClr_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d = 1'b0;
      end
    endcase

    // Register writes
    if (isWr) begin
      regAck_d = 1'b1;
      case (regAddr)
        `CDQ_CHAIN_BASE:  chainBase_d = regWdata[7:0];
        `CDQ_IRQ_LEVEL:   irqLevel_d = regWdata[2:0];
        `CDQ_IRQ_VECTOR:  irqVector_d = regWdata[7:0];
        `CDQ_CTRL1:       ctrl1_d = regWdata;
        `CDQ_BITSET2: begin
          bitSet2_d = bitSet2_q | regWdata;
          if (regWdata[`CDQ_B2_SIM_ACQ]) begin
            fifoWp_d = 5'h0;
          end
        end
        `CDQ_BITCLR2: begin
          bitSet2_d = bitSet2_q & ~regWdata;
          if (regWdata[`CDQ_B2_SIM_ACQ]) begin
            fifoRp_d = 5'h0;
          end
        end
        `CDQ_W_TEST_ADDR: wTestAddr_d = regWdata[10:0];
        `CDQ_R_TEST_ADDR: rTestAddr_d = regWdata[10:0];
        `CDQ_TESTWORD_HI: testHi_d = regWdata;
        `CDQ_TESTWORD_LO: begin
          // Colliding addresses leave the word unwritten
          if (bitSet2_q[`CDQ_B2_MEM_TEST] && wTestAddr_q != rTestAddr_q && !bufWe) begin
            bufWe = 1'b1;
            bufWa = wTestAddr_q;
            bufWd = {testHi_q, regWdata};
          end
        end
        `CDQ_SIM_FIFO_WR: begin
          if (!simAcq) begin
            fifoWe = 1'b1;
            fifoWp_d = fifoWp_q + 5'h01;
          end
        end
        default: begin
          if (regAddr >= `CDQ_THR_FIRST && regAddr <= `CDQ_THR_LAST) begin
            thrWe = 1'b1;
          end
        end
      endcase
    end

    // Register reads
    if (blkStart) begin
      blkDone_d = 1'b0;
    end
    if (isRd) begin
      regAck_d = 1'b1;
      if (regAddr < `CDQ_OUTBUF_END) begin
        if (bitSet2_q[`CDQ_B2_MEM_TEST]) begin
          regRdata_d = outBuf[rTestAddr_q];
        end else if (blkDone_q || rdPtr_q == commitPtr_q) begin
          // Nothing more for this block: error or filler
          if (ctrl1_q[`CDQ_C1_BERR_EN]) begin
            regAck_d = 1'b0;
            regBerr_d = 1'b1;
          end else begin
            regRdata_d = {5'h0, `CDQ_TYPE_INVALID, 24'h0};
          end
        end else begin
          regRdata_d = rdWord;
          rdPtr_d = rdPtr_q + 11'h001;
          if (rdWord[26:24] == `CDQ_TYPE_EOB) begin
            blkDone_d = ctrl1_q[`CDQ_C1_BLOCK_END];
          end
        end
      end else begin
        case (regAddr)
          `CDQ_CHAIN_BASE:  regRdata_d = {24'h0, chainBase_q};
          `CDQ_IRQ_LEVEL:   regRdata_d = {29'h0, irqLevel_q};
          `CDQ_IRQ_VECTOR:  regRdata_d = {24'h0, irqVector_q};
          `CDQ_STATUS:      regRdata_d = {29'h0, rdPtr_q == commitPtr_q,
                                          storedEv_q == `CDQ_MEB_EVENTS, busy_q};
          `CDQ_CTRL1:       regRdata_d = {16'h0, ctrl1_q};
          `CDQ_BITSET2:     regRdata_d = {16'h0, bitSet2_q};
          `CDQ_EVCNT_LO:    regRdata_d = {16'h0, eventCnt_q[15:0]};
          `CDQ_EVCNT_HI:    regRdata_d = {24'h0, eventCnt_q[23:16]};
          default: begin
            if (regAddr >= `CDQ_THR_FIRST && regAddr <= `CDQ_THR_LAST) begin
              regRdata_d = {23'h0, thresh[regAddr[5:1]]};
            end
          end
        endcase
      end
    end
    // Stored-event count follows trailer writes and trailer reads
    storedEv_d = storedEv_q + {5'h0, state_q == ST_EOB}
               - {5'h0, rdPtr_d != rdPtr_q && rdWord[26:24] == `CDQ_TYPE_EOB};
  end

  // ---------------------------------------------------------------
  // Registers; thresholds deliberately have no reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;   cnt_q <= 7'h0;       accCnt_q <= 6'h0;
      wrOff_q <= 11'h0;     commitPtr_q <= 11'h0; rdPtr_q <= 11'h0;
      storedEv_q <= 6'h0;   eventCnt_q <= 24'h0; busy_q <= 1'b0;
      chanSel_q <= 5'h0;    secClr_q <= 1'b0;    gatePrev_q <= 1'b0;
      fcPrev_q <= 1'b0;     bitSet2_q <= 16'h0;  ctrl1_q <= 16'h0;
      irqLevel_q <= 3'h0;   irqVector_q <= 8'h0; chainBase_q <= `CDQ_CHAIN_RESET;
      wTestAddr_q <= 11'h0; rTestAddr_q <= 11'h0; testHi_q <= 16'h0;
      fifoWp_q <= 5'h0;     fifoRp_q <= 5'h0;    blkDone_q <= 1'b0;
      regRdata_q <= 32'h0;  regAck_q <= 1'b0;    regBerr_q <= 1'b0;
    end else begin
      state_q <= state_d;   cnt_q <= cnt_d;      accCnt_q <= accCnt_d;
      wrOff_q <= wrOff_d;   commitPtr_q <= commitPtr_d; rdPtr_q <= rdPtr_d;
      storedEv_q <= storedEv_d; eventCnt_q <= eventCnt_d; busy_q <= busy_d;
      chanSel_q <= chanSel_d;   secClr_q <= secClr_d;   gatePrev_q <= gateLvl;
      fcPrev_q <= fcLvl;    bitSet2_q <= bitSet2_d; ctrl1_q <= ctrl1_d;
      irqLevel_q <= irqLevel_d; irqVector_q <= irqVector_d; chainBase_q <= chainBase_d;
      wTestAddr_q <= wTestAddr_d; rTestAddr_q <= rTestAddr_d; testHi_q <= testHi_d;
      fifoWp_q <= fifoWp_d; fifoRp_q <= fifoRp_d; blkDone_q <= blkDone_d;
      regRdata_q <= regRdata_d; regAck_q <= regAck_d; regBerr_q <= regBerr_d;
    end
  end

  // Memory writes
  always_ff @(posedge clk) begin
    if (bufWe) begin
      outBuf[bufWa] <= bufWd;
    end
    if (thrWe) begin
      thresh[regAddr[5:1]] <= regWdata[8:0];
    end
    if (fifoWe) begin
      simFifo[fifoWp_q] <= regWdata;
    end
  end

  assign regRdata     = regRdata_q;
  assign regAck       = regAck_q;
  assign regBerr      = regBerr_q;
  assign busy         = busy_q;
  assign chanSel      = chanSel_q;
  assign sectionClear = secClr_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_reset_state: assert property ($fell(reset) |-> eventCnt_q == 24'h0 && rdPtr_q == 11'h0
      && commitPtr_q == 11'h0 && storedEv_q == 6'h0) else $error("reset state wrong");
  a_irq_reset: assert property ($fell(reset) |-> irqLevel_q == 3'h0 && irqVector_q == 8'h0)
      else $error("interrupt regs not zero");
  a_chain_reset: assert property ($fell(reset) |-> chainBase_q == `CDQ_CHAIN_RESET)
      else $error("chain base reset wrong");
  a_gate_busy: assert property (state_q == ST_IDLE && gateRise && !regWr
      |=> busy_q && state_q == ST_CONV && eventCnt_q == $past(eventCnt_q) + 24'h1)
      else $error("gate did not start");
  a_abort_idle: assert property (state_q == ST_CONV && fcRise |=> state_q == ST_IDLE && !busy_q
      && sectionClear) else $error("abort failed");
  a_empty_skip: assert property (state_q == ST_HEAD && accCnt_q == 6'h0
      && !bitSet2_q[`CDQ_B2_EMPTY_EN] |=> $stable(commitPtr_q) && state_q == ST_IDLE)
      else $error("empty event stored");
  a_full_busy: assert property (storedEv_q == `CDQ_MEB_EVENTS |-> busy_q)
      else $error("full buffer not busy");
  a_test_commit: assert property (regWr && regAddr == `CDQ_TESTWORD_LO && state_q == ST_IDLE
      && bitSet2_q[`CDQ_B2_MEM_TEST] && wTestAddr_q != rTestAddr_q
      |=> outBuf[$past(wTestAddr_q)] == {$past(testHi_q), $past(regWdata)})
      else $error("test word not committed");
  a_fifo_wrap: assert property (fifoWe |=> fifoWp_q == $past(fifoWp_q) + 5'h1)
      else $error("fifo pointer wrong");
  a_drain_berr: assert property (regRd && regAddr < `CDQ_OUTBUF_END
      && !bitSet2_q[`CDQ_B2_MEM_TEST] && rdPtr_q == commitPtr_q
      && ctrl1_q[`CDQ_C1_BERR_EN] |=> regBerr_q && !regAck_q)
      else $error("no bus error on drain");

  c_event_stored: cover property (state_q == ST_EOB ##1 state_q == ST_FULL);
  c_abort: cover property (state_q == ST_CONV && fcRise);
  c_berr: cover property (regBerr_q);
  c_meb_full: cover property (storedEv_q == `CDQ_MEB_EVENTS);
endmodule
`default_nettype wire

// ---- design/cdq_cfg.svh ----
`ifndef CDQ_CFG_SVH
`define CDQ_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ---------------------------------------------------------------
`define CDQ_OUTBUF_END    16'h0800
`define CDQ_CHAIN_BASE    16'h1004
`define CDQ_IRQ_LEVEL     16'h100a
`define CDQ_IRQ_VECTOR    16'h100c
`define CDQ_STATUS        16'h100e
`define CDQ_CTRL1         16'h1010
`define CDQ_EVCNT_LO      16'h1024
`define CDQ_EVCNT_HI      16'h1026
`define CDQ_BITSET2       16'h1032
`define CDQ_BITCLR2       16'h1034
`define CDQ_W_TEST_ADDR   16'h1036
`define CDQ_TESTWORD_HI   16'h1038
`define CDQ_TESTWORD_LO   16'h103a
`define CDQ_SIM_FIFO_WR   16'h103e
`define CDQ_EVCNT_RESET   16'h1040
`define CDQ_R_TEST_ADDR   16'h1064
`define CDQ_SW_CONVERT    16'h1068
`define CDQ_THR_FIRST     16'h1080
`define CDQ_THR_LAST      16'h10be

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CDQ_B2_MEM_TEST   0
`define CDQ_B2_OVR_OFF    3
`define CDQ_B2_ZERO_OFF   4
`define CDQ_B2_SIM_ACQ    6
`define CDQ_B2_EMPTY_EN   12
`define CDQ_C1_BLOCK_END  2
`define CDQ_C1_BERR_EN    5
`define CDQ_THR_KILL      8
`define CDQ_CHAIN_RESET   8'haa
`define CDQ_FIFO_OV       12
`define CDQ_TYPE_DATA     3'h0
`define CDQ_TYPE_HEAD     3'h2
`define CDQ_TYPE_EOB      3'h4
`define CDQ_TYPE_INVALID  3'h6
`define CDQ_MEB_EVENTS    6'h20
`define CDQ_LAST_CHAN     5'h1f

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CDQ_CLK_PERIOD_NS 10
`define CDQ_CONV_TIME_NS  600
`define CDQ_CONV_CYCLES   ((`CDQ_CONV_TIME_NS + `CDQ_CLK_PERIOD_NS - 1) / `CDQ_CLK_PERIOD_NS)

`endif

// ---- design/cdq_pkg.sv ----
package cdq_pkg;
  // Acquisition sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONV,
    ST_SAMPLE,
    ST_HEAD,
    ST_EOB,
    ST_FULL
  } cdq_state_type;
endpackage

// ---- design/cdq_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Three-stage pin synchroniser; level changes once stages 2 and 3 agree
// ---------------------------------------------------------------
module cdq_sync
  import cdq_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      level
);
  logic s1_q, s2_q, s3_q; // Stage 1 feeds only stage 2
  logic lvl_q, lvl_d;     // Filtered level

  // Accept a change only when the last two stages agree
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  // Shift chain and filtered level
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q  <= pinIn;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule
`default_nettype wire

// ---- dv/cdq_qac_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Charge section model: one converted value for each channel
// ---------------------------------------------------------------
module cdq_qac_model (
  input  wire logic [4:0]  chanSel,
  input  wire logic        sectionClear,
  output logic      [11:0] chanValue,
  output logic             chanOverflow
);
  // Value tells the channel, so a mixed-up order shows at once
  assign chanValue = {chanSel, 7'h05};
  // Top channel overflows; default suppression must drop it
  assign chanOverflow = (chanSel == 5'h1f);
  // Held values stay until the next event; the clear is not modelled
  logic unusedClear;
  assign unusedClear = sectionClear;
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cdq_cfg.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module testbench
  import cdq_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------
  logic        clk;           // 100 MHz
  logic        reset;         // Synchronous, active high
  logic [15:0] regAddr;       // Register offset
  logic        regWr;         // Write strobe
  logic        regRd;         // Read strobe
  logic [15:0] regWdata;      // Write data
  logic        blkStart;      // New block read
  logic        gatePin;       // Gate pin
  logic        fastClearPin;  // Fast clear pin
  logic [11:0] chanValue;     // From charge model
  logic        chanOverflow;  // From charge model
  logic [31:0] regRdata;      // Read data
  logic        regAck;        // Acknowledge
  logic        regBerr;       // Bus error
  logic        busy;          // Busy output
  logic [4:0]  chanSel;       // Sampled channel
  logic        sectionClear;  // Section clear
  logic [31:0] rd;            // Last read word
  logic        be;            // Last access ended in bus error
  int          errors;
  int          tests_run;
  int          i;

  cdq_acq_ctrl dut_u (.clk(clk), .reset(reset), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .blkStart(blkStart), .gatePin(gatePin),
    .fastClearPin(fastClearPin), .chanValue(chanValue), .chanOverflow(chanOverflow),
    .regRdata(regRdata), .regAck(regAck), .regBerr(regBerr), .busy(busy),
    .chanSel(chanSel), .sectionClear(sectionClear));
  cdq_qac_model qac_u (.chanSel(chanSel), .sectionClear(sectionClear),
    .chanValue(chanValue), .chanOverflow(chanOverflow));

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  // One strobe cycle, then wait a few cycles for ack or bus error
  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
    int k;
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWr = wr;
    regRd = !wr;
    @(negedge clk);
    regWr = 1'b0;
    regRd = 1'b0;
    for (k = 0; k < 4 && regAck !== 1'b1 && regBerr !== 1'b1; k++) @(negedge clk);
    rd = regRdata;
    be = regBerr;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    acc(1'b0, a, 16'h0000);
    `CHK(rd, e)
  endtask

  // Gate pulse long enough for the pin filter; fc aborts in conversion,
  // stay means the buffer fills and busy must not drop
  task automatic gate(input logic fc = 1'b0, input logic stay = 1'b0);
    int k;
    @(negedge clk);
    gatePin = 1'b1;
    repeat (6) @(negedge clk);
    gatePin = 1'b0;
    fastClearPin = fc;
    `CHK(busy, 1'b1)
    for (k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clk);
    fastClearPin = 1'b0;
    `CHK(busy, stay)
    `CHK(sectionClear, !stay)
  endtask

  // Header, data in 0,16,1,17.. order, trailer; sim events carry loaded words
  task automatic rd_ev(input int n, input logic [23:0] ev, input logic sim);
    int k;
    logic [4:0] ch;
    acc(1'b0, 16'h0000, 16'h0000);
    `CHK({rd[26:24], rd[13:8]}, {3'h2, 6'(n)})
    for (k = sim ? 0 : 1; n > 0 && k < (sim ? 32 : 31); k++) begin
      acc(1'b0, 16'h0000, 16'h0000);
      ch = k[0] ? 5'(16 + k / 2) : 5'(k / 2);
      if (sim) `CHK(rd[12:0], 13'(k == 0 ? 32'h120 : k + 32'h100))
      else `CHK({rd[26:24], rd[20:16], rd[12:0]}, {3'h0, ch, 1'b0, ch, 7'h05})
    end
    acc(1'b0, 16'h0000, 16'h0000);
    `CHK({rd[26:24], rd[23:0]}, {3'h4, ev})
  endtask

  task automatic blk();
    @(negedge clk);
    blkStart = 1'b1;
    @(negedge clk);
    blkStart = 1'b0;
  endtask

  task automatic summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: whole run needs far fewer cycles than this
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    summarize();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    {regAddr, regWdata, regWr, regRd, blkStart, gatePin, fastClearPin} = '0;
    errors = 0;
    tests_run = 0;
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    rd_chk(`CDQ_CHAIN_BASE, 32'h000000aa);
    rd_chk(`CDQ_IRQ_LEVEL, 32'h00000000);
    rd_chk(`CDQ_IRQ_VECTOR, 32'h00000000);
    rd_chk(`CDQ_EVCNT_LO, 32'h00000000);
    rd_chk(16'h0000, 32'h06000000);
    // High thresholds reject every channel
    for (i = 0; i < 32; i++) acc(1'b1, 16'(`CDQ_THR_FIRST + 2 * i), 16'h00ff);
    gate();
    rd_chk(`CDQ_EVCNT_LO, 32'h00000001);
    rd_chk(16'h0000, 32'h06000000);
    acc(1'b1, `CDQ_BITSET2, 16'h1000);
    // Aborted event counts but stores nothing, even with empty events on
    gate(1'b1);
    rd_chk(16'h0000, 32'h06000000);
    gate();
    // Open thresholds, channel 0 killed; channel 31 overflow suppressed
    for (i = 0; i < 32; i++) acc(1'b1, 16'(`CDQ_THR_FIRST + 2 * i), i == 0 ? 16'h0100 : 16'h0000);
    gate();
    acc(1'b1, `CDQ_CTRL1, 16'h0020);
    rd_ev(0, 24'd3, 1'b0);
    rd_ev(30, 24'd4, 1'b0);
    acc(1'b0, 16'h0000, 16'h0000);
    `CHK(be, 1'b1)
    // Block end with bus error, then block end alone
    acc(1'b1, `CDQ_CTRL1, 16'h0024);
    gate();
    gate();
    rd_ev(30, 24'd5, 1'b0);
    acc(1'b0, 16'h0000, 16'h0000);
    `CHK(be, 1'b1)
    blk();
    acc(1'b1, `CDQ_CTRL1, 16'h0004);
    rd_ev(30, 24'd6, 1'b0);
    rd_chk(16'h0000, 32'h06000000);
    blk();
    acc(1'b1, `CDQ_CTRL1, 16'h0000);
    acc(1'b1, `CDQ_THR_FIRST, 16'h0000);
    // Simulated acquisition; 33 words so the first entry is overwritten
    acc(1'b1, `CDQ_BITSET2, 16'h1040);
    acc(1'b1, `CDQ_BITCLR2, 16'h0040);
    for (i = 0; i < 33; i++) acc(1'b1, `CDQ_SIM_FIFO_WR, 16'(32'h100 + i));
    acc(1'b1, `CDQ_BITSET2, 16'h0040);
    gate();
    rd_ev(32, 24'd7, 1'b1);
    acc(1'b1, `CDQ_BITCLR2, 16'h0040);
    // Direct buffer access, then equal addresses must not store
    acc(1'b1, `CDQ_BITSET2, 16'h0001);
    acc(1'b1, `CDQ_W_TEST_ADDR, 16'h0005);
    acc(1'b1, `CDQ_TESTWORD_HI, 16'habcd);
    acc(1'b1, `CDQ_TESTWORD_LO, 16'h1234);
    acc(1'b1, `CDQ_W_TEST_ADDR, 16'h0006);
    acc(1'b1, `CDQ_R_TEST_ADDR, 16'h0005);
    rd_chk(16'h0000, 32'habcd1234);
    acc(1'b1, `CDQ_W_TEST_ADDR, 16'h0005);
    acc(1'b1, `CDQ_TESTWORD_HI, 16'h5555);
    acc(1'b1, `CDQ_TESTWORD_LO, 16'h5555);
    rd_chk(16'h0000, 32'habcd1234);
    // Fill all event slots; the last event keeps busy until one is read
    acc(1'b1, `CDQ_BITCLR2, 16'h0001);
    acc(1'b1, `CDQ_THR_FIRST, 16'h0100);
    for (i = 0; i < 31; i++) gate();
    gate(1'b0, 1'b1);
    rd_chk(`CDQ_STATUS, 32'h00000003);
    rd_ev(30, 24'd8, 1'b0);
    repeat (2) @(negedge clk);
    `CHK(busy, 1'b0)
    summarize();
  end
endmodule
`default_nettype wire
